// ### common/io_port_pkg.sv
package io_port_pkg;
  // Port space geometry
  localparam int PORT_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  // Transfer size codes presented by the core
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;
  // Byte counts for each size
  localparam logic [2:0] BYTES_1 = 3'h1;
  localparam logic [2:0] BYTES_2 = 3'h2;
  localparam logic [2:0] BYTES_4 = 3'h4;
  // Space indication driven with every bus request: low selects port space
  localparam logic MEM_IO_PORT = 1'b0;
  // Ports kept free of peripherals by the system
  localparam logic [15:0] RESERVED_LO = 16'h00F8;
  localparam logic [15:0] RESERVED_HI = 16'h00FF;
  // Values after reset
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [31:0] DATA_RST = 32'h00000000;
  localparam logic [3:0] BE_RST = 4'h0;
  localparam logic [2:0] COUNT_RST = 3'h0;

  typedef enum logic [1:0] {IDLE, ISSUE, WAIT_ACK, WAIT_DROP} state_type;
endpackage

// ### src/io_port_access_unit.sv
`timescale 1ns/100ps
// Summary of operation
// - Separate 64K byte-port space, 16-bit number
// - Accesses past FFFFh wrap to port 0
// - Transfers of 8, 16 or 32 bits
// - Aligned word or dword takes one cycle
// - Unaligned access uses extra bus cycles
// - Write completes before next instruction retires
// - Space indication low on port cycles
// - Only port instructions start port cycles
// - Port cycle parity errors never masked
// - Port number from immediate or count register
module io_port_access_unit
(
  input wire logic clock,
  input wire logic rst,
  input wire logic io_valid,
  input wire logic io_port_instr,
  input wire logic io_write,
  input wire logic [1:0] io_size,
  input wire logic io_use_count,
  input wire logic [15:0] io_imm_port,
  input wire logic [15:0] io_count_port,
  input wire logic [31:0] io_wdata,
  output logic io_pending,
  output logic retire_stall,
  output logic io_done,
  output logic io_refused,
  output logic [31:0] io_rdata,
  output logic parity_error,
  output logic bus_strobe,
  output logic bus_mem_io,
  output logic bus_write,
  output logic [15:0] bus_addr,
  output logic [3:0] bus_be,
  output logic [31:0] bus_wdata,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_parity_err
);

  // Largest naturally aligned piece that fits at this lane
  function automatic logic [2:0] piece_len(input logic [1:0] lo, input logic [2:0] left);
    if (lo == 2'h0 && left >= io_port_pkg::BYTES_4)
      piece_len = io_port_pkg::BYTES_4;
    else if (!lo[0] && left >= io_port_pkg::BYTES_2)
      piece_len = io_port_pkg::BYTES_2;
    else
      piece_len = io_port_pkg::BYTES_1;
  endfunction

  // Lane mask for a piece of the given length, starting at lane 0
  function automatic logic [3:0] lane_mask(input logic [2:0] len);
    lane_mask = (len == io_port_pkg::BYTES_4) ? 4'hF :
                (len == io_port_pkg::BYTES_2) ? 4'h3 : 4'h1;
  endfunction

  io_port_pkg::state_type state_reg;
  logic [15:0] addr_reg;
  logic [2:0] left_reg;
  logic [2:0] done_reg;
  logic write_reg;
  logic [31:0] wdata_reg;
  logic [31:0] acc_reg;
  logic pending_reg;
  logic stall_reg;
  logic done_pulse_reg;
  logic refused_reg;
  logic [31:0] rdata_reg;
  logic parity_reg;
  logic strobe_reg;
  logic bus_write_reg;
  logic [15:0] bus_addr_reg;
  logic [3:0] bus_be_reg;
  logic [31:0] bus_wdata_reg;
  logic mem_io_reg;
  logic ack_meta;
  logic ack_s;
  logic [31:0] rdata_meta;
  logic [31:0] rdata_s;
  logic par_meta;
  logic par_s;

  // Core request decode; port number source chosen per instruction form
  wire logic start = (state_reg == io_port_pkg::IDLE) && io_valid && io_port_instr;
  wire logic refuse = (state_reg == io_port_pkg::IDLE) && io_valid && !io_port_instr;
  wire logic [15:0] sel_port = io_use_count ? io_count_port : io_imm_port;
  wire logic [2:0] size_bytes = (io_size == io_port_pkg::SIZE_DWORD) ? io_port_pkg::BYTES_4 :
                                (io_size == io_port_pkg::SIZE_WORD) ? io_port_pkg::BYTES_2 :
                                io_port_pkg::BYTES_1;

  // Piece split: aligned access is one piece, unaligned falls into several
  wire logic [1:0] lo = addr_reg[1:0];
  wire logic [2:0] plen = piece_len(lo, left_reg);
  wire logic [3:0] pmask = lane_mask(plen);
  wire logic [3:0] be_next = 4'(pmask << lo);
  wire logic [31:0] bits_mask = {{8{pmask[3]}}, {8{pmask[2]}}, {8{pmask[1]}}, {8{pmask[0]}}};
  wire logic [31:0] wdata_lane = (wdata_reg >> {done_reg[1:0], 3'h0}) << {lo, 3'h0};
  wire logic [31:0] rd_piece = ((rdata_s >> {lo, 3'h0}) & bits_mask) << {done_reg[1:0], 3'h0};
  // 16-bit sum drops the carry, so a piece past FFFFh lands at port 0
  wire logic [15:0] addr_next = addr_reg + 16'(plen);
  wire logic ack_done = (state_reg == io_port_pkg::WAIT_ACK) && ack_s;

  // Bus answers come from outside the clock domain; first stage feeds only the second
  always_ff @(posedge clock)
  begin
    ack_meta <= bus_ack;
    ack_s <= ack_meta;
    rdata_meta <= bus_rdata;
    rdata_s <= rdata_meta;
    par_meta <= bus_parity_err;
    par_s <= par_meta;
  end

  // Sequencer: issue piece, wait for ack, wait for ack to drop, repeat
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= io_port_pkg::IDLE;
      addr_reg <= io_port_pkg::ADDR_RST;
      left_reg <= io_port_pkg::COUNT_RST;
      done_reg <= io_port_pkg::COUNT_RST;
      write_reg <= 1'b0;
      wdata_reg <= io_port_pkg::DATA_RST;
      acc_reg <= io_port_pkg::DATA_RST;
      pending_reg <= 1'b0;
      stall_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        io_port_pkg::IDLE:
          if (start)
          begin
            addr_reg <= sel_port;
            left_reg <= size_bytes;
            done_reg <= io_port_pkg::COUNT_RST;
            write_reg <= io_write;
            wdata_reg <= io_wdata;
            acc_reg <= io_port_pkg::DATA_RST;
            pending_reg <= 1'b1;
            stall_reg <= io_write;
            state_reg <= io_port_pkg::ISSUE;
          end
        io_port_pkg::ISSUE:
          state_reg <= io_port_pkg::WAIT_ACK;
        io_port_pkg::WAIT_ACK:
          if (ack_s)
          begin
            acc_reg <= acc_reg | rd_piece;
            addr_reg <= addr_next;
            left_reg <= left_reg - plen;
            done_reg <= done_reg + plen;
            state_reg <= io_port_pkg::WAIT_DROP;
          end
        io_port_pkg::WAIT_DROP:
          if (!ack_s)
          begin
            if (left_reg == io_port_pkg::COUNT_RST)
            begin
              pending_reg <= 1'b0;
              stall_reg <= 1'b0;
              state_reg <= io_port_pkg::IDLE;
            end
            else
              state_reg <= io_port_pkg::ISSUE;
          end
      endcase
    end
  end

  // Core-side pulses and read data
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      done_pulse_reg <= 1'b0;
      refused_reg <= 1'b0;
      rdata_reg <= io_port_pkg::DATA_RST;
      parity_reg <= 1'b0;
    end
    else
    begin
      done_pulse_reg <= (state_reg == io_port_pkg::WAIT_DROP) && !ack_s
                        && (left_reg == io_port_pkg::COUNT_RST);
      refused_reg <= refuse;
      parity_reg <= ack_done && par_s;
      if ((state_reg == io_port_pkg::WAIT_DROP) && !ack_s && (left_reg == io_port_pkg::COUNT_RST))
        rdata_reg <= acc_reg;
    end
  end

  // Bus request outputs; strobe held until the ack is seen
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      strobe_reg <= 1'b0;
      bus_write_reg <= 1'b0;
      bus_addr_reg <= io_port_pkg::ADDR_RST;
      bus_be_reg <= io_port_pkg::BE_RST;
      bus_wdata_reg <= io_port_pkg::DATA_RST;
      mem_io_reg <= io_port_pkg::MEM_IO_PORT;
    end
    else if (state_reg == io_port_pkg::ISSUE)
    begin
      strobe_reg <= 1'b1;
      bus_write_reg <= write_reg;
      bus_addr_reg <= {addr_reg[15:2], 2'h0};
      bus_be_reg <= be_next;
      bus_wdata_reg <= wdata_lane;
      mem_io_reg <= io_port_pkg::MEM_IO_PORT;
    end
    else if (ack_done)
      strobe_reg <= 1'b0;
  end

  assign io_pending = pending_reg;
  assign retire_stall = stall_reg;
  assign io_done = done_pulse_reg;
  assign io_refused = refused_reg;
  assign io_rdata = rdata_reg;
  assign parity_error = parity_reg;
  assign bus_strobe = strobe_reg;
  assign bus_mem_io = mem_io_reg;
  assign bus_write = bus_write_reg;
  assign bus_addr = bus_addr_reg;
  assign bus_be = bus_be_reg;
  assign bus_wdata = bus_wdata_reg;

  // Checks on the sequencer
  a_space_port: assert property (@(posedge clock) disable iff (rst)
    bus_strobe |-> (bus_mem_io == 1'b0))
    else $error("port cycle without port-space indication");
  a_dword_single: assert property (@(posedge clock) disable iff (rst)
    (state_reg == io_port_pkg::ISSUE && done_reg == 3'h0 && left_reg == 3'h4 && lo == 2'h0)
    |=> (bus_be == 4'hF) ##1 (state_reg == io_port_pkg::WAIT_ACK))
    else $error("aligned dword not issued as one cycle");
  a_unaligned_split: assert property (@(posedge clock) disable iff (rst)
    (state_reg == io_port_pkg::ISSUE && lo[0] && left_reg > 3'h1)
    |=> (bus_be != 4'hF) && (bus_be[0] == 1'b0))
    else $error("unaligned access not split");
  a_stall_write: assert property (@(posedge clock) disable iff (rst)
    $fell(retire_stall) |-> io_done)
    else $error("write stall released before completion");
  a_pending_last: assert property (@(posedge clock) disable iff (rst)
    io_done |-> !io_pending && (left_reg == 3'h0) && $past(io_pending))
    else $error("pending dropped early");
  a_parity_seen: assert property (@(posedge clock) disable iff (rst)
    (ack_done && par_s) |=> parity_error)
    else $error("parity error masked");
  a_refuse_other: assert property (@(posedge clock) disable iff (rst)
    refuse |=> io_refused && !io_pending ##1 !bus_strobe)
    else $error("non-port request started a cycle");
  a_port_source: assert property (@(posedge clock) disable iff (rst)
    start |=> (addr_reg == $past(sel_port)) && (left_reg == $past(size_bytes)))
    else $error("wrong port number or size loaded");
  a_wrap_top: assert property (@(posedge clock) disable iff (rst)
    (ack_done && addr_reg == 16'hFFFF) |=> (addr_reg == 16'h0000))
    else $error("port address did not wrap");
endmodule

// ### tb/io_port_model.sv
`timescale 1ns/100ps
// Peripheral side: byte ports behind a four-phase ack, lines scrambled when idle
module io_port_model
(
  input wire logic clock,
  input wire logic bus_strobe,
  input wire logic bus_mem_io,
  input wire logic bus_write,
  input wire logic [15:0] bus_addr,
  input wire logic [3:0] bus_be,
  input wire logic [31:0] bus_wdata,
  input wire logic [3:0] ack_delay,
  input wire logic perr_inject,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  output logic bus_parity_err
);
  logic [7:0] mem [logic [15:0]];
  logic [19:0] log_q [$];
  logic [15:0] a;

  // Contents of a port never written; nothing sits in the reserved block, lines float high
  function automatic logic [7:0] pat(input logic [15:0] p);
    if (p >= io_port_pkg::RESERVED_LO && p <= io_port_pkg::RESERVED_HI)
      return 8'hFF;
    return p[7:0] ^ p[15:8] ^ 8'h3C;
  endfunction

  // One piece per strobe; data settles 2 + ack_delay cycles before ack, ack held until strobe drops
  initial
  begin
    bus_ack = 1'b0;
    bus_rdata = 32'h5A5A5A5A;
    bus_parity_err = 1'b0;
    forever
    begin
      @(posedge clock);
      if (bus_strobe === 1'b1 && bus_mem_io === 1'b0) // Port cycles only
      begin
        log_q.push_back({bus_addr, bus_be});
        for (int k = 0; k < 4; k++)
        begin
          a = bus_addr + 16'(k);
          if (bus_be[k] && bus_write)
            mem[a] = bus_wdata[8*k +: 8]; // Each byte lands alone, any piece order
          bus_rdata[8*k +: 8] <= mem.exists(a) ? mem[a] : pat(a);
        end
        bus_parity_err <= perr_inject;
        repeat (2 + ack_delay) @(posedge clock);
        bus_ack <= 1'b1;
        while (bus_strobe === 1'b1) @(posedge clock);
        bus_ack <= 1'b0;
        bus_rdata <= ~bus_rdata; // Released lines must not keep old data
        bus_parity_err <= 1'b0;
      end
    end
  end
endmodule

// ### tb/io_port_access_unit_tb.sv
`timescale 1ns/100ps
// Core-side requests; bus pieces and data checked against the split rule
module io_port_access_unit_tb;
  typedef struct packed {logic w; logic [1:0] sz; logic uc; logic [15:0] port; logic [31:0] wd;} row_type;
  logic clock = 0, rst = 1, io_valid = 0, io_port_instr = 1, io_write = 0, io_use_count = 0;
  logic [1:0] io_size = 0;
  logic [15:0] io_imm_port = 0, io_count_port = 0, bus_addr;
  logic [31:0] io_wdata = 0, io_rdata, bus_wdata, bus_rdata;
  logic io_pending, retire_stall, io_done, io_refused, parity_error, bus_strobe, bus_mem_io;
  logic bus_write, bus_ack, bus_parity_err, perr_inject = 0;
  logic [3:0] bus_be, ack_delay = 0;
  logic [7:0] shadow [logic [15:0]];
  int failures = 0, num_checks = 0, perr_cnt = 0;
  row_type rows [11] = '{
    {1'b1, 2'h0, 1'b0, 16'h0010, 32'h000000C3}, {1'b1, 2'h1, 1'b1, 16'h0022, 32'h0000BEEF},
    {1'b1, 2'h2, 1'b0, 16'h0004, 32'h11223344}, {1'b1, 2'h2, 1'b1, 16'h0001, 32'hA1B2C3D4},
    {1'b1, 2'h1, 1'b0, 16'h0003, 32'h00005566}, {1'b1, 2'h2, 1'b0, 16'hFFFE, 32'h99887766},
    {1'b0, 2'h2, 1'b0, 16'h0001, 32'h0}, {1'b0, 2'h1, 1'b1, 16'h0003, 32'h0},
    {1'b0, 2'h2, 1'b1, 16'hFFFE, 32'h0}, {1'b0, 2'h0, 1'b0, 16'h00F8, 32'h0},
    {1'b0, 2'h1, 1'b0, 16'hFFFF, 32'h0}};

  io_port_access_unit uut (.clock(clock), .rst(rst), .io_valid(io_valid),
    .io_port_instr(io_port_instr), .io_write(io_write), .io_size(io_size),
    .io_use_count(io_use_count), .io_imm_port(io_imm_port), .io_count_port(io_count_port),
    .io_wdata(io_wdata), .io_pending(io_pending), .retire_stall(retire_stall),
    .io_done(io_done), .io_refused(io_refused), .io_rdata(io_rdata),
    .parity_error(parity_error), .bus_strobe(bus_strobe), .bus_mem_io(bus_mem_io),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .bus_parity_err(bus_parity_err));
  io_port_model pm (.clock(clock), .bus_strobe(bus_strobe), .bus_mem_io(bus_mem_io),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata),
    .ack_delay(ack_delay), .perr_inject(perr_inject), .bus_ack(bus_ack),
    .bus_rdata(bus_rdata), .bus_parity_err(bus_parity_err));

  always #10 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One access; the unused port source carries a wrong number on purpose
  task automatic access(input row_type r);
    logic [15:0] p;
    logic [7:0] e;
    int n, c, i, j;
    p = r.port;
    n = (r.sz == io_port_pkg::SIZE_WORD) ? 2 : (r.sz == io_port_pkg::SIZE_DWORD) ? 4 : 1;
    pm.log_q.delete();
    io_valid = 1;
    io_write = r.w;
    io_size = r.sz;
    io_use_count = r.uc;
    io_imm_port = r.uc ? ~r.port : r.port;
    io_count_port = r.uc ? r.port : ~r.port;
    io_wdata = r.wd;
    @(negedge clock);
    io_valid = 0;
    for (i = 0; io_done !== 1'b1 && i < 400; i++) @(negedge clock);
    if (i == 400)
    begin
      failures++;
      end_of_test();
    end
    j = 0;
    for (i = 0; j < n; i++)
    begin
      c = (p[1:0] == 0 && n - j >= 4) ? 4 : (p[0] == 0 && n - j >= 2) ? 2 : 1;
      check(32'(pm.log_q[i]), {12'h000, p & 16'hFFFC, 4'(((1 << c) - 1) << p[1:0])});
      repeat (c)
      begin
        e = r.w ? r.wd[8*j +: 8] : (shadow.exists(p) ? shadow[p] : pm.pat(p));
        check(r.w ? pm.mem[p] : io_rdata[8*j +: 8], e);
        shadow[p] = e;
        p++;
        j++;
      end
    end
    check(pm.log_q.size(), i);
  endtask

  // Every strobe is port space, keeps the access pending and stalls retire only on writes
  always @(negedge clock)
  begin
    if (bus_strobe === 1'b1)
    begin
      check(bus_mem_io, io_port_pkg::MEM_IO_PORT);
      check({io_pending, retire_stall}, {1'b1, bus_write});
    end
    if (parity_error === 1'b1)
      perr_cnt++;
  end

  initial
  begin
    repeat (8) @(negedge clock);
    check({io_pending, retire_stall, io_done, io_refused, parity_error, bus_strobe}, 0);
    rst = 0;
    $display("reset test done");
    foreach (rows[i])
    begin
      ack_delay = i[0] ? 4'hA : 4'h0;
      access(rows[i]);
      $display("row %0d done", i);
    end
    perr_inject = 1;
    access(rows[6]);
    check(perr_cnt, 3);
    perr_inject = 0;
    $display("parity test done");
    pm.log_q.delete();
    io_port_instr = 0;
    io_valid = 1;
    @(negedge clock);
    io_valid = 0;
    for (int i = 0; io_refused !== 1'b1 && i < 4; i++) @(negedge clock);
    check(io_refused, 1);
    repeat (12) @(negedge clock);
    check(pm.log_q.size(), 0);
    $display("refusal test done");
    end_of_test();
  end
endmodule
